// File: tws_slave_port.sv
// Two-wire serial slave port in front of a 512 x 8 memory array, with a
// small APB register block. Assumes scl/sda/pins are asynchronous to
// ref_clk and that ref_clk runs well above the serial clock.
//
// Summary of operation
// RQ1 - Data line only changes with clock low, except start and stop.
// RQ2 - Ninth clock of each byte is an acknowledge slot driven by receiver.
// RQ3 - Missing acknowledge ends the operation; device waits for new address.
// RQ4 - Master must not acknowledge the last byte it reads.
// RQ5 - Device answers only when address bits 7-4 equal its type code.
// RQ6 - Address bits 3 and 2 must match the two select pins.
// RQ7 - Address bit 1 is the page bit, the ninth array address bit.
// RQ8 - Address bit 0 gives direction: 0 write, 1 read.
// RQ9 - Write: next byte is word address, joined with page into latch.
// RQ10 - Read uses latch low byte plus page bit, no word address.
// RQ11 - Latch advances by one after each data byte, wrapping to zero.
// RQ12 - Any number of bytes per operation, no page limit or buffer.
// RQ13 - Read: eight bits out, then acknowledge continues, none ends.
// RQ14 - Write: eight bits in, then device drives acknowledge.
// RQ15 - All bytes travel most significant bit first.
// RQ16 - Array written after eighth bit; earlier start or stop changes nothing.
// RQ17 - No busy time; device is addressable right after a write.
// RQ18 - Protect high blocks writes, acknowledges and latch advance.
// RQ19 - Master ends a read with no-acknowledge then stop or start.
// RQ20 - Random read: write address, word address, repeated start, read.
// RQ21 - Stop is data rising with clock high; it abandons any operation.
// RQ22 - Start is data falling with clock high; it restarts addressing.
// RQ23 - Output bits change on clock fall, inputs captured on clock rise.
// RQ24 - Clock and data lines are synchronised and edges found by ref_clk.
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_slave_port #(
  parameter int          ADDR_W    = `TWS_ADDR_W,
  parameter logic [3:0]  TYPE_CODE = 4'h5   // Arbitrary device-type code
) (
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Serial link pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output wire logic        sda_out,
  output wire logic        sda_oe,
  // Strap and protect pins
  input  wire logic        select_pin_high,
  input  wire logic        select_pin_low,
  input  wire logic        write_protect,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr
);
  import tws_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  // Page bit is wired as the top latch bit, so only a 9-bit array fits
  generate
    if (ADDR_W != `TWS_ADDR_W) begin : g_bad_addr_w
      $error("tws_slave_port: ADDR_W must be 9");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // State and array
  // ----------------------------------------------------------------------
  tws_regs_t  cur_r;
  tws_regs_t  cur_nxt;
  logic [7:0] mem [0:(1<<`TWS_ADDR_W)-1];

  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic       byte_done;
  logic       addr_match;
  logic       wp_eff;
  logic       mem_we;
  logic       apb_wr;
  logic       hit_ctrl;
  logic       hit_stat;

  // ----------------------------------------------------------------------
  // Line events, found on synchronised copies only
  // ----------------------------------------------------------------------
  // Second and third stages are compared; first stage feeds nothing else
  always_comb begin
    scl_rise  = clk_en & cur_r.scl_s & ~cur_r.scl_p;                  // [RQ24]
    scl_fall  = clk_en & ~cur_r.scl_s & cur_r.scl_p;                  // [RQ24]
    start_ev  = clk_en & cur_r.scl_s & cur_r.scl_p
                & cur_r.sda_p & ~cur_r.sda_s;                         // [RQ22]
    stop_ev   = clk_en & cur_r.scl_s & cur_r.scl_p
                & ~cur_r.sda_p & cur_r.sda_s;                         // [RQ21]
    byte_done = scl_fall & (cur_r.cnt == `TWS_BITS_PER_BYTE);         // [RQ2]
    addr_match = (cur_r.sh[`TWS_SA_TYPE_HI:`TWS_SA_TYPE_LO] == TYPE_CODE)  // [RQ5]
                 & (cur_r.sh[`TWS_SA_SEL_HI] == cur_r.selh_s)                // [RQ6]
                 & (cur_r.sh[`TWS_SA_SEL_LO] == cur_r.sell_s);               // [RQ6]
    wp_eff    = cur_r.wp_s | cur_r.soft_wp;
    // Write lands as the eighth bit ends, before the acknowledge slot
    mem_we    = byte_done & (cur_r.phase == TWS_WDATA) & ~wp_eff
                & ~start_ev & ~stop_ev;                               // [RQ16] [RQ18]
  end

  // ----------------------------------------------------------------------
  // APB decode (zero wait states)
  // ----------------------------------------------------------------------
  assign hit_ctrl = (paddr == `TWS_OFF_CTRL);
  assign hit_stat = (paddr == `TWS_OFF_STAT);
  assign apb_wr   = psel & penable & pwrite & hit_ctrl;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~(hit_ctrl | hit_stat);  // Unmapped offset

  // Read mux over registered state only
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata[`TWS_CTRL_WPROT] = cur_r.soft_wp;
    end else if (hit_stat) begin
      prdata[ADDR_W-1:0]              = cur_r.latch;
      prdata[`TWS_STAT_ACTIVE]        = (cur_r.phase != TWS_IDLE);
      prdata[`TWS_STAT_PHASE_LO+:4]   = cur_r.phase;
    end
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    cur_nxt = cur_r;
    if (clk_en) begin
      // Two-stage synchronisers, third stage keeps history for edges
      cur_nxt.scl_m  = scl_in;                                        // [RQ24]
      cur_nxt.scl_s  = cur_r.scl_m;
      cur_nxt.scl_p  = cur_r.scl_s;
      cur_nxt.sda_m  = sda_in;
      cur_nxt.sda_s  = cur_r.sda_m;
      cur_nxt.sda_p  = cur_r.sda_s;
      cur_nxt.wp_m   = write_protect;
      cur_nxt.wp_s   = cur_r.wp_m;
      cur_nxt.selh_m = select_pin_high;
      cur_nxt.selh_s = cur_r.selh_m;
      cur_nxt.sell_m = select_pin_low;
      cur_nxt.sell_s = cur_r.sell_m;
      if (apb_wr) begin
        cur_nxt.soft_wp = pwdata[`TWS_CTRL_WPROT];
      end

      if (start_ev) begin
        // Start wins over everything, even mid-byte or mid-read
        cur_nxt.phase  = TWS_DEVADDR;                                 // [RQ22] [RQ20]
        cur_nxt.cnt    = 4'h0;
        cur_nxt.sda_oe = 1'b0;
      end else if (stop_ev) begin
        cur_nxt.phase  = TWS_IDLE;                                    // [RQ21]
        cur_nxt.sda_oe = 1'b0;
      end else begin
        case (cur_r.phase)
          TWS_IDLE: begin
            cur_nxt.sda_oe = 1'b0;
          end
          TWS_DEVADDR, TWS_WORDADDR, TWS_WDATA: begin
            if (scl_rise) begin
              cur_nxt.sh  = {cur_r.sh[6:0], cur_r.sda_s};             // [RQ15] [RQ23]
              cur_nxt.cnt = cur_r.cnt + 4'h1;
            end else if (byte_done) begin
              cur_nxt.cnt = 4'h0;
              if (cur_r.phase == TWS_DEVADDR) begin
                if (addr_match) begin
                  // Page bit becomes the top latch bit for either direction
                  cur_nxt.latch[ADDR_W-1] = cur_r.sh[`TWS_SA_PAGE];   // [RQ7] [RQ10]
                  cur_nxt.after_ack = cur_r.sh[`TWS_SA_RW] ?
                                      TWS_RDATA : TWS_WORDADDR;       // [RQ8]
                  cur_nxt.phase  = TWS_ACK;                           // [RQ17]
                  cur_nxt.sda_oe = 1'b1;
                end else begin
                  cur_nxt.phase = TWS_IDLE;                           // [RQ5] [RQ6]
                end
              end else if (cur_r.phase == TWS_WORDADDR) begin
                cur_nxt.latch = {cur_r.latch[ADDR_W-1], cur_r.sh};    // [RQ9]
                cur_nxt.after_ack = TWS_WDATA;
                cur_nxt.phase  = TWS_ACK;
                cur_nxt.sda_oe = 1'b1;
              end else if (wp_eff) begin
                // Protected: no acknowledge, latch left where it was
                cur_nxt.phase = TWS_IDLE;                             // [RQ18] [RQ3]
              end else begin
                cur_nxt.latch = cur_r.latch + 9'h001;                 // [RQ11] [RQ12]
                cur_nxt.after_ack = TWS_WDATA;
                cur_nxt.phase  = TWS_ACK;                             // [RQ14]
                cur_nxt.sda_oe = 1'b1;
              end
            end
          end
          TWS_ACK: begin
            // Hold the acknowledge low through the ninth clock
            if (scl_fall) begin
              cur_nxt.phase = cur_r.after_ack;
              cur_nxt.cnt   = 4'h0;
              if (cur_r.after_ack == TWS_RDATA) begin
                cur_nxt.sh     = mem[cur_r.latch];                    // [RQ10]
                cur_nxt.sda_oe = ~mem[cur_r.latch][7];                // [RQ15] [RQ23]
              end else begin
                cur_nxt.sda_oe = 1'b0;                                // [RQ2]
              end
            end
          end
          TWS_RDATA: begin
            if (scl_rise) begin
              cur_nxt.cnt = cur_r.cnt + 4'h1;
            end else if (byte_done) begin
              // Release for the master's acknowledge and step the latch
              cur_nxt.sda_oe = 1'b0;                                  // [RQ2] [RQ13]
              cur_nxt.latch  = cur_r.latch + 9'h001;                  // [RQ11]
              cur_nxt.phase  = TWS_RACK;
            end else if (scl_fall) begin
              cur_nxt.sh     = {cur_r.sh[6:0], 1'b0};
              cur_nxt.sda_oe = ~cur_r.sh[6];                          // [RQ23] [RQ1]
            end
          end
          TWS_RACK: begin
            if (scl_rise) begin
              // High line means the master wants no more bytes
              cur_nxt.phase = cur_r.sda_s ? TWS_IDLE : TWS_RNEXT;     // [RQ13] [RQ3] [RQ19]
            end
          end
          TWS_RNEXT: begin
            if (scl_fall) begin
              cur_nxt.sh     = mem[cur_r.latch];                      // [RQ12]
              cur_nxt.sda_oe = ~mem[cur_r.latch][7];
              cur_nxt.cnt    = 4'h0;
              cur_nxt.phase  = TWS_RDATA;
            end
          end
          default: begin
            cur_nxt.phase  = TWS_IDLE;
            cur_nxt.sda_oe = 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Idle lines are high, so the scl and sda synchronisers reset high to avoid a false start
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cur_r           <= '0;
      cur_r.scl_m     <= 1'b1;
      cur_r.scl_s     <= 1'b1;
      cur_r.scl_p     <= 1'b1;
      cur_r.sda_m     <= 1'b1;
      cur_r.sda_s     <= 1'b1;
      cur_r.sda_p     <= 1'b1;
      cur_r.phase     <= TWS_IDLE;
      cur_r.after_ack <= TWS_IDLE;
      cur_r.soft_wp   <= `TWS_CTRL_RST;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Array write port; contents are not reset, like a real cell array
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[cur_r.latch] <= cur_r.sh;                                   // [RQ16]
    end
  end

  // Open-drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = cur_r.sda_oe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_rd_nack;
    (cur_r.phase == TWS_RACK) && scl_rise && cur_r.sda_s;
  endsequence

  sequence s_wr_byte_ok;
    (cur_r.phase == TWS_WDATA) && byte_done && !wp_eff && !start_ev && !stop_ev;
  endsequence

  property p_start_abort;
    start_ev |=> (cur_r.phase == TWS_DEVADDR) && (cur_r.cnt == 4'h0) && !sda_oe;
  endproperty
  a_start_abort: assert property (p_start_abort)                     // [RQ22]
    else $error("start did not restart addressing");

  property p_stop_idle;
    stop_ev && !start_ev |=> (cur_r.phase == TWS_IDLE) && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle)                         // [RQ21]
    else $error("stop did not end the operation");

  property p_type_mismatch;
    (cur_r.phase == TWS_DEVADDR) && byte_done && !start_ev && !stop_ev
      && (cur_r.sh[7:4] != TYPE_CODE) |=> !sda_oe && (cur_r.phase == TWS_IDLE);
  endproperty
  a_type_mismatch: assert property (p_type_mismatch)                 // [RQ5]
    else $error("foreign type code was acknowledged");

  property p_select_mismatch;
    (cur_r.phase == TWS_DEVADDR) && byte_done && !start_ev && !stop_ev
      && ((cur_r.sh[3] != cur_r.selh_s) || (cur_r.sh[2] != cur_r.sell_s)) |=> !sda_oe;
  endproperty
  a_select_mismatch: assert property (p_select_mismatch)             // [RQ6]
    else $error("select pins mismatch but acknowledged");

  property p_protect_blocks;
    (cur_r.phase == TWS_WDATA) && byte_done && wp_eff && !start_ev && !stop_ev
      |-> !mem_we ##1 (!sda_oe && $stable(cur_r.latch));
  endproperty
  a_protect_blocks: assert property (p_protect_blocks)               // [RQ18]
    else $error("protected write changed array, latch or acked");

  property p_write_step;
    s_wr_byte_ok |-> mem_we ##1 (cur_r.latch == $past(cur_r.latch) + 9'h001) && sda_oe;
  endproperty
  a_write_step: assert property (p_write_step)                       // [RQ11]
    else $error("write byte not stored, stepped and acked");

  property p_nack_ends;
    s_rd_nack |=> (cur_r.phase == TWS_IDLE) && !sda_oe;
  endproperty
  a_nack_ends: assert property (p_nack_ends)                         // [RQ3]
    else $error("read continued after no-acknowledge");

  property p_stable_high;
    cur_r.scl_s && $past(cur_r.scl_s) && (cur_r.phase != TWS_IDLE)
      && (cur_r.phase != TWS_DEVADDR) |-> $stable(sda_oe);
  endproperty
  a_stable_high: assert property (p_stable_high)                     // [RQ1]
    else $error("data line moved while clock high");

  property p_read_release;
    (cur_r.phase == TWS_RDATA) && byte_done && !start_ev && !stop_ev
      |=> !sda_oe && (cur_r.phase == TWS_RACK);
  endproperty
  a_read_release: assert property (p_read_release)                   // [RQ13]
    else $error("device kept line in master ack slot");

endmodule // tws_slave_port

// File: tws_consts.svh
// Constants for the two-wire memory slave port: offsets, field positions,
// reset values and array sizes. Included by the package and the design.
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define TWS_ADDR_W       9
`define TWS_BYTE_W       8
`define TWS_BITS_PER_BYTE 4'h8

// ----------------------------------------------------------------------
// Slave address byte fields
// ----------------------------------------------------------------------
`define TWS_SA_TYPE_HI   7
`define TWS_SA_TYPE_LO   4
`define TWS_SA_SEL_HI    3
`define TWS_SA_SEL_LO    2
`define TWS_SA_PAGE      1
`define TWS_SA_RW        0

// ----------------------------------------------------------------------
// APB register map (byte addresses) and fields
// ----------------------------------------------------------------------
`define TWS_OFF_CTRL     12'h000
`define TWS_OFF_STAT     12'h004
`define TWS_CTRL_WPROT   0
`define TWS_STAT_ACTIVE  16
`define TWS_STAT_PHASE_LO 20
`define TWS_CTRL_RST     1'h0

`endif

// File: tws_pkg.sv
// Types shared by the two-wire memory slave port.
// Assumes tws_consts.svh is on the include path.
`include "tws_consts.svh"

package tws_pkg;

  // --------------------------------------------------------------------
  // Protocol phases
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    TWS_IDLE,
    TWS_DEVADDR,
    TWS_WORDADDR,
    TWS_WDATA,
    TWS_ACK,
    TWS_RDATA,
    TWS_RACK,
    TWS_RNEXT
  } tws_phase_t;

  // --------------------------------------------------------------------
  // Whole state of the port, registered as one word
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                   scl_m;
    logic                   scl_s;
    logic                   scl_p;
    logic                   sda_m;
    logic                   sda_s;
    logic                   sda_p;
    logic                   wp_m;
    logic                   wp_s;
    logic                   selh_m;
    logic                   selh_s;
    logic                   sell_m;
    logic                   sell_s;
    tws_phase_t             phase;
    tws_phase_t             after_ack;
    logic [3:0]             cnt;
    logic [7:0]             sh;
    logic [`TWS_ADDR_W-1:0] latch;
    logic                   sda_oe;
    logic                   soft_wp;
  } tws_regs_t;

endpackage : tws_pkg

// File: tws_bus_master.sv
// Behavioural two-wire bus master: drives the serial clock and pulls data.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/1ps

module tws_bus_master (
  // Clock
  input  wire logic ref_clk,
  // Serial wire
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_pull
);
  // ----------------------------------------------------------------
  // Idle bus: clock high, data released
  // ----------------------------------------------------------------
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // One clock: data set 300 ns into low phase, sampled mid-high
  task automatic bit_cycle(input logic b, output logic r);
    repeat (3) @(posedge ref_clk);
    sda_pull <= ~b;
    @(posedge ref_clk);
    scl <= 1'b1;
    repeat (2) @(posedge ref_clk);
    r = sda_wire;
    repeat (2) @(posedge ref_clk);
    scl <= 1'b0;
  endtask

  // Extra low time lets the device drop a late acknowledge first
  task automatic start_cond();
    repeat (5) @(posedge ref_clk);
    sda_pull <= 1'b0;
    @(posedge ref_clk);
    scl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sda_pull <= 1'b1;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b0;
  endtask

  // Clock left high afterwards: it stands still between frames
  task automatic stop_cond();
    repeat (3) @(posedge ref_clk);
    sda_pull <= 1'b1;
    @(posedge ref_clk);
    scl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sda_pull <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask

  // Byte out, then release data for the acknowledge slot
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], r);
    bit_cycle(1'b1, r);
    ack = ~r;
  endtask

  // Byte in; last wanted byte gets no acknowledge
  task automatic recv_byte(input logic give_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      d[i] = r;
    end
    bit_cycle(~give_ack, r);
  endtask
endmodule // tws_bus_master

// File: tb.sv
// Self-checking bench for the two-wire memory slave port: APB register
// checks and serial traffic through the bus master model.
// Assumes tws_consts.svh, tws_pkg.sv and the master model compile first.
`timescale 1ns/1ps
`include "tws_consts.svh"

module tb;
  localparam logic [3:0] TC = 4'h9;  // Arbitrary device-type code
  localparam logic SEL_H = 1'b1;
  localparam logic SEL_L = 1'b0;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        ref_clk;
  logic        reset;
  logic        clk_en;
  logic        scl;
  logic        sda_pull;
  logic        sda_wire;
  logic        sda_out;
  logic        sda_oe;
  logic        select_pin_high;
  logic        select_pin_low;
  logic        write_protect;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ack;
  logic        b;
  logic [7:0]  d;
  logic [31:0] rd;
  logic        er;
  int          fail_count;
  int          samples_checked;
  int          cycles;

  // Open-drain wire with pull-up
  assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

  tws_slave_port #(.TYPE_CODE(TC)) uut (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .select_pin_high(select_pin_high), .select_pin_low(select_pin_low),
    .write_protect(write_protect), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  tws_bus_master m (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Leading edge keeps a release and a new setup in separate steps
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_latch(input logic [8:0] exp);
    apb(1'b0, `TWS_OFF_STAT, 32'h0, rd, er);
    check({23'h0, rd[8:0]}, {23'h0, exp});
  endtask

  function automatic logic [7:0] sa(input logic pg, input logic rw);
    return {TC, SEL_H, SEL_L, pg, rw};
  endfunction

  // Write header loads the latch
  task automatic set_addr(input logic pg, input logic [7:0] w);
    m.start_cond();
    m.send_byte(sa(pg, 1'b0), ack);
    check({31'h0, ack}, 32'h1);
    m.send_byte(w, ack);
    check({31'h0, ack}, 32'h1);
  endtask

  // Read n bytes (low byte of exp first), last one not acknowledged
  task automatic read_seq(input logic pg, input int n, input logic [23:0] exp);
    m.start_cond();
    m.send_byte(sa(pg, 1'b1), ack);
    check({31'h0, ack}, 32'h1);
    for (int i = 0; i < n; i++) begin
      m.recv_byte(i < n - 1, d);
      check({24'h0, d}, {24'h0, exp[8*i +: 8]});
    end
    m.stop_cond();
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    select_pin_high = SEL_H;
    select_pin_low = SEL_L;
    write_protect = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // Reset values, read-only status, unmapped offset
    apb(1'b0, `TWS_OFF_CTRL, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'b1, `TWS_OFF_STAT, 32'hFFFFFFFF, rd, er);
    apb(1'b0, `TWS_OFF_STAT, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'b1, 12'h008, 32'h1, rd, er);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    check(rd, 32'h0);
    // Three bytes across the top of the array
    set_addr(1'b1, 8'hFE);
    for (int i = 0; i < 3; i++) begin
      m.send_byte(8'(24'h963CA5 >> (8 * i)), ack);
      check({31'h0, ack}, 32'h1);
    end
    m.stop_cond();
    check_latch(9'h001);
    // Selective read through repeated start, then current address
    set_addr(1'b1, 8'hFE);
    read_seq(1'b1, 2, 24'h003CA5);
    check_latch(9'h000);
    read_seq(1'b0, 1, 24'h000096);
    // Wrong type code, upper select, lower select
    for (int i = 0; i < 3; i++) begin
      m.start_cond();
      m.send_byte(sa(1'b0, 1'b1) ^ (8'h10 >> i), ack);
      check({31'h0, ack}, 32'h0);
      m.stop_cond();
    end
    // Protect by pin, then by control bit
    for (int i = 0; i < 2; i++) begin
      write_protect <= (i == 0);
      apb(1'b1, `TWS_OFF_CTRL, {31'h0, i == 1}, rd, er);
      apb(1'b0, `TWS_OFF_CTRL, 32'h0, rd, er);
      check(rd, {31'h0, i == 1});
      set_addr(1'b1, 8'hFE);
      m.send_byte(8'h5A, ack);
      check({31'h0, ack}, 32'h0);
      m.stop_cond();
      check_latch(9'h1FE);
    end
    write_protect <= 1'b0;
    apb(1'b1, `TWS_OFF_CTRL, 32'h0, rd, er);
    // Low clock enable freezes state, so this control write must not land
    clk_en <= 1'b0;
    apb(1'b1, `TWS_OFF_CTRL, 32'h1, rd, er);
    clk_en <= 1'b1;
    apb(1'b0, `TWS_OFF_CTRL, 32'h0, rd, er);
    check(rd, 32'h0);
    // Seven data bits then a start: memory keeps its byte
    set_addr(1'b1, 8'hFE);
    // Status mid-write: latch loaded, busy, waiting for data
    repeat (4) @(posedge ref_clk);
    apb(1'b0, `TWS_OFF_STAT, 32'h0, rd, er);
    check(rd, {8'h0, 4'(tws_pkg::TWS_WDATA), 3'h0, 1'b1, 7'h0, 9'h1FE});
    for (int i = 0; i < 7; i++) m.bit_cycle(1'b0, b);
    set_addr(1'b1, 8'hFE);
    read_seq(1'b1, 1, 24'h0000A5);
    results();
  end
endmodule // tb
